// >>> design/liuc_rx_strap.sv
`timescale 1ns/10ps
`include "liuc_consts.svh"

// Contract
// - buildout select high bypasses transmit shaping
// - select honoured only DS3/STS-1 hardware mode
// - hardware mode receiver follows power-on pin
// - host mode reuses pins as data/select
// - equalizer pin used only in hardware mode
// - output recovered clock, data on rising
// - invert pin or bit moves data falling
// - positive data pulses per positive mark
// - single rail negative output flags violations
module liuc_rx_strap (
   input wire logic core_clk_i,
   input wire logic reset_i,
   input wire logic link_clk_i,
   input wire logic line_buildout_bypass_select_i,
   input wire logic receiver_power_on_i,
   input wire logic receive_equalizer_enable_i,
   input wire logic recovered_clock_invert_i,
   input wire logic host_mode_i,
   input wire logic single_rail_i,
   input wire logic [1:0] rate_sel_i,
   input wire logic host_rx_power_on_i,
   input wire logic host_equalizer_enable_i,
   input wire logic host_rx_clk_invert_i,
   input wire logic host_single_rail_i,
   input wire logic line_pos_mark_i,
   input wire logic line_neg_mark_i,
   input wire logic line_valid_i,
   output logic line_ready_o,
   output logic buildout_bypass_o,
   output logic receiver_enable_o,
   output logic equalizer_enable_o,
   output logic host_serial_data_in_o,
   output logic host_chip_select_o,
   output logic recovered_clock_out_o,
   output logic receive_positive_data_o,
   output logic receive_negative_data_o
);

   // ---------------- core clock domain ----------------

   liuc_pkg::liuc_pins_t pins_raw;
   liuc_pkg::liuc_pins_t pins_s1_q;
   liuc_pkg::liuc_pins_t pins_s2_q;
   liuc_pkg::liuc_pins_t pins_s3_q;
   liuc_pkg::liuc_pins_t pins_q;
   logic hw_mode;
   logic bypass_d;
   logic buildout_q;
   logic rx_en_q;
   logic eq_q;
   logic sdi_q;
   logic cs_q;
   liuc_pkg::liuc_xcfg_t xcfg_q;

   // strap pins gathered into one vector
   assign pins_raw.host_mode = host_mode_i;
   assign pins_raw.single_rail = single_rail_i;
   assign pins_raw.rate = liuc_pkg::liuc_rate_t'(rate_sel_i);
   assign pins_raw.buildout_bypass = line_buildout_bypass_select_i;
   assign pins_raw.rx_power_on = receiver_power_on_i;
   assign pins_raw.eq_enable = receive_equalizer_enable_i;
   assign pins_raw.clk_invert = recovered_clock_invert_i;

   // three-stage pin synchroniser
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         pins_s1_q <= `LIUC_PINS_RST;
         pins_s2_q <= `LIUC_PINS_RST;
         pins_s3_q <= `LIUC_PINS_RST;
      end else begin
         pins_s1_q <= pins_raw;
         pins_s2_q <= pins_s1_q;
         pins_s3_q <= pins_s2_q;
      end
   end

   // a bit changes once stages two and three agree
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         pins_q <= `LIUC_PINS_RST;
      end else begin
         pins_q <= (pins_s2_q & pins_s3_q) | (pins_q & (pins_s2_q | pins_s3_q));
      end
   end

   assign hw_mode = !pins_q.host_mode;

   // honour select only in DS3/STS-1 hardware mode
   assign bypass_d = hw_mode && (pins_q.rate == liuc_pkg::LIUC_RATE_DS3 ||
                                 pins_q.rate == liuc_pkg::LIUC_RATE_STS1) &&
                     pins_q.buildout_bypass;

   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         buildout_q <= `LIUC_CFG_RST;
      end else begin
         buildout_q <= bypass_d;
      end
   end

   // receiver power follows pin in hardware mode
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         rx_en_q <= `LIUC_CFG_RST;
      end else begin
         rx_en_q <= hw_mode ? pins_q.rx_power_on : host_rx_power_on_i;
      end
   end

   // equalizer pin ignored in host mode
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         eq_q <= `LIUC_CFG_RST;
      end else begin
         eq_q <= hw_mode ? pins_q.eq_enable : host_equalizer_enable_i;
      end
   end

   // shared pins become serial data and select
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         sdi_q <= `LIUC_CFG_RST;
         cs_q <= `LIUC_CFG_RST;
      end else begin
         sdi_q <= pins_q.host_mode & pins_q.rx_power_on;
         cs_q <= pins_q.host_mode & pins_q.clk_invert;
      end
   end

   // invert from pin or from host bit
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         xcfg_q <= `LIUC_XCFG_RST;
      end else begin
         xcfg_q.clk_invert <= hw_mode ? pins_q.clk_invert : host_rx_clk_invert_i;
         xcfg_q.rx_enable <= hw_mode ? pins_q.rx_power_on : host_rx_power_on_i;
         xcfg_q.single_rail <= hw_mode ? pins_q.single_rail : host_single_rail_i;
      end
   end

   assign buildout_bypass_o = buildout_q;
   assign receiver_enable_o = rx_en_q;
   assign equalizer_enable_o = eq_q;
   assign host_serial_data_in_o = sdi_q;
   assign host_chip_select_o = cs_q;

   a_buildout_follow: assert property (@(posedge core_clk_i) disable iff (reset_i)
      (hw_mode && pins_q.rate == liuc_pkg::LIUC_RATE_DS3) |=>
      buildout_bypass_o == $past(pins_q.buildout_bypass))
      else $error("buildout bypass does not follow select");

   // select ignored in E3 or host mode
   a_buildout_ignore: assert property (@(posedge core_clk_i) disable iff (reset_i)
      (pins_q.host_mode || pins_q.rate == liuc_pkg::LIUC_RATE_E3) |=> !buildout_bypass_o)
      else $error("buildout select honoured when it must be ignored");

   a_rx_power_pin: assert property (@(posedge core_clk_i) disable iff (reset_i)
      hw_mode ##1 hw_mode |-> receiver_enable_o == $past(pins_q.rx_power_on))
      else $error("receiver enable differs from power-on pin");

   // shared pins only carry host roles in host mode
   a_host_reuse: assert property (@(posedge core_clk_i) disable iff (reset_i)
      pins_q.host_mode |=> host_serial_data_in_o == $past(pins_q.rx_power_on) &&
      host_chip_select_o == $past(pins_q.clk_invert) && receiver_enable_o ==
      $past(host_rx_power_on_i))
      else $error("host mode pin reuse broken");

   // equalizer pin has no effect in host mode
   a_eq_ignore: assert property (@(posedge core_clk_i) disable iff (reset_i)
      pins_q.host_mode |=> equalizer_enable_o == $past(host_equalizer_enable_i))
      else $error("equalizer pin acted in host mode");

   logic [4:0] lrst_cnt_q;
   logic lrst_req_q;

   // reset tail so that a short core reset still spans several link edges
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         lrst_cnt_q <= `LIUC_LRST_HOLD;
      end else if (lrst_cnt_q != 5'h00) begin
         lrst_cnt_q <= lrst_cnt_q - 5'h01;
      end
   end

   // glitch-free reset request handed to the link domain
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         lrst_req_q <= `LIUC_LRST_REQ_RST;
      end else begin
         lrst_req_q <= (lrst_cnt_q != 5'h00);
      end
   end

   // ---------------- recovered clock domain ----------------

   logic lrst_s1_q;
   logic lrst_s2_q;
   logic lrst_s3_q;
   logic link_rst;
   liuc_pkg::liuc_xcfg_t x_s1_q;
   liuc_pkg::liuc_xcfg_t x_s2_q;
   liuc_pkg::liuc_xcfg_t x_s3_q;
   liuc_pkg::liuc_xcfg_t lcfg_q;
   logic mark;
   logic same_pol;
   logic last_pos_q;
   logic had_mark_q;
   liuc_pkg::liuc_rx_word_t in_word;
   liuc_pkg::liuc_rx_word_t out_word;
   logic out_valid;
   logic out_ready;
   logic pos_q;
   logic neg_q;

   // reset brought into the link domain
   always_ff @(posedge link_clk_i) begin
      lrst_s1_q <= lrst_req_q;
      lrst_s2_q <= lrst_s1_q;
      lrst_s3_q <= lrst_s2_q;
   end
   assign link_rst = lrst_s2_q | lrst_s3_q;

   // config levels cross through three stages
   always_ff @(posedge link_clk_i) begin
      if (link_rst) begin
         x_s1_q <= `LIUC_XCFG_RST;
         x_s2_q <= `LIUC_XCFG_RST;
         x_s3_q <= `LIUC_XCFG_RST;
      end else begin
         x_s1_q <= xcfg_q;
         x_s2_q <= x_s1_q;
         x_s3_q <= x_s2_q;
      end
   end

   // crossed level accepted once stages agree
   always_ff @(posedge link_clk_i) begin
      if (link_rst) begin
         lcfg_q <= `LIUC_XCFG_RST;
      end else begin
         lcfg_q <= (x_s2_q & x_s3_q) | (lcfg_q & (x_s2_q | x_s3_q));
      end
   end

   // violation: two marks in a row of one polarity, or both marks at once
   assign mark = line_pos_mark_i | line_neg_mark_i;
   assign same_pol = had_mark_q && (line_pos_mark_i == last_pos_q);
   assign in_word.pos_mark = line_pos_mark_i;
   assign in_word.neg_mark = line_neg_mark_i;
   assign in_word.violation = (mark && same_pol) || (line_pos_mark_i && line_neg_mark_i);

   // last mark polarity for violation tracking
   always_ff @(posedge link_clk_i) begin
      if (link_rst) begin
         last_pos_q <= `LIUC_CFG_RST;
         had_mark_q <= `LIUC_CFG_RST;
      end else if (line_valid_i && line_ready_o && mark) begin
         last_pos_q <= line_pos_mark_i;
         had_mark_q <= 1'b1;
      end
   end

   // drain stalls while the receiver is off
   assign out_ready = lcfg_q.rx_enable;

   liuc_fifo #(
      .WIDTH($bits(liuc_pkg::liuc_rx_word_t)),
      .DEPTH(`LIUC_FIFO_DEPTH)
   ) u_rx_fifo (
      .clk_i(link_clk_i),
      .reset_i(link_rst),
      .in_valid_i(line_valid_i),
      .in_ready_o(line_ready_o),
      .in_data_i(in_word),
      .out_valid_o(out_valid),
      .out_ready_i(out_ready),
      .out_data_o(out_word)
   );

   // positive output pulses on each positive mark
   always_ff @(posedge link_clk_i) begin
      if (link_rst) begin
         pos_q <= `LIUC_DATA_RST;
      end else begin
         pos_q <= out_valid && out_ready && out_word.pos_mark;
      end
   end

   // negative output carries violations in single rail
   always_ff @(posedge link_clk_i) begin
      if (link_rst) begin
         neg_q <= `LIUC_DATA_RST;
      end else if (out_valid && out_ready) begin
         neg_q <= lcfg_q.single_rail ? out_word.violation : out_word.neg_mark;
      end else begin
         neg_q <= 1'b0;
      end
   end

   // data changes on the link rising edge
   assign receive_positive_data_o = pos_q;
   assign receive_negative_data_o = neg_q;

   // inverted clock puts data change on its falling edge
   assign recovered_clock_out_o = link_clk_i ^ lcfg_q.clk_invert;

   // clock out low just before a data update when not inverted
   a_clk_polarity: assert property (@(posedge link_clk_i) disable iff (link_rst || lrst_req_q)
      recovered_clock_out_o == lcfg_q.clk_invert)
      else $error("recovered clock polarity wrong");

   // invert level arrives within a few link cycles
   a_invert_cross: assert property (@(posedge link_clk_i) disable iff (link_rst || lrst_req_q)
      $rose(x_s3_q.clk_invert) && x_s2_q.clk_invert |=> lcfg_q.clk_invert)
      else $error("clock invert not applied after crossing");

   // a popped positive mark shows as one pulse
   a_pos_mark: assert property (@(posedge link_clk_i) disable iff (link_rst || lrst_req_q)
      (out_valid && out_ready) |=> receive_positive_data_o == $past(out_word.pos_mark))
      else $error("positive data does not match positive mark");

   // single rail carries the violation flag
   a_violation_rail: assert property (@(posedge link_clk_i) disable iff (link_rst || lrst_req_q)
      (out_valid && out_ready && lcfg_q.single_rail) |=>
      receive_negative_data_o == $past(out_word.violation))
      else $error("violation flag missing in single rail");

   // dual rail carries the negative marks
   a_neg_mark_dual: assert property (@(posedge link_clk_i) disable iff (link_rst || lrst_req_q)
      (out_valid && out_ready && !lcfg_q.single_rail) |=>
      receive_negative_data_o == $past(out_word.neg_mark))
      else $error("negative data does not match negative mark");

   // outputs quiet while receiver is off
   a_quiet_off: assert property (@(posedge link_clk_i) disable iff (link_rst || lrst_req_q)
      !out_ready |=> !receive_positive_data_o && !receive_negative_data_o)
      else $error("receive data active while receiver off");

endmodule : liuc_rx_strap

// >>> design/liuc_consts.svh
`ifndef LIUC_CONSTS_SVH
`define LIUC_CONSTS_SVH

// storage depth of the receive word buffer
`define LIUC_FIFO_DEPTH 4
// reset value of the single-bit config outputs and mark flags
`define LIUC_CFG_RST 1'h0
// reset value of the receive data outputs
`define LIUC_DATA_RST 1'h0
// reset value of the filtered strap vector
`define LIUC_PINS_RST 8'h00
// reset value of the crossed config levels
`define LIUC_XCFG_RST 3'h0
// core cycles the link reset request outlasts the core reset
`define LIUC_LRST_HOLD 5'h10
// reset value of the link reset request
`define LIUC_LRST_REQ_RST 1'h1

`endif

// >>> design/liuc_pkg.sv
package liuc_pkg;

   // line rate selected by strap
   typedef enum logic [1:0] {
      LIUC_RATE_E3 = 2'b00,
      LIUC_RATE_DS3 = 2'b01,
      LIUC_RATE_STS1 = 2'b10,
      LIUC_RATE_RSVD = 2'b11
   } liuc_rate_t;

   // strap pins as seen on the package
   typedef struct packed {
      logic host_mode;
      logic single_rail;
      liuc_rate_t rate;
      logic buildout_bypass;
      logic rx_power_on;
      logic eq_enable;
      logic clk_invert;
   } liuc_pins_t;

   // config levels that cross into the recovered clock domain
   typedef struct packed {
      logic clk_invert;
      logic rx_enable;
      logic single_rail;
   } liuc_xcfg_t;

   // one recovered bit period
   typedef struct packed {
      logic pos_mark;
      logic neg_mark;
      logic violation;
   } liuc_rx_word_t;

endpackage : liuc_pkg

// >>> design/liuc_fifo.sv
`timescale 1ns/10ps
`include "liuc_consts.svh"

module liuc_fifo #(
   parameter int WIDTH = 3,
   parameter int DEPTH = `LIUC_FIFO_DEPTH
) (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   // depth must be a power of two for the wrap pointers
   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad_size
      $error("liuc_fifo: DEPTH must be a power of two >= 2");
   end

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW:0] wr_q;
   logic [AW:0] rd_q;
   logic full;
   logic empty;
   logic push;
   logic pop;

   // honest flags from pointers with a wrap bit
   assign empty = (wr_q == rd_q);
   assign full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
   assign in_ready_o = !full;
   assign out_valid_o = !empty;
   assign push = in_valid_i && !full;
   assign pop = out_ready_i && !empty;
   assign out_data_o = mem_q[rd_q[AW-1:0]];

   // write side
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         wr_q <= '0;
      end else if (push) begin
         wr_q <= wr_q + 1'b1;
      end
   end

   // storage, no reset needed
   always_ff @(posedge clk_i) begin
      if (push) begin
         mem_q[wr_q[AW-1:0]] <= in_data_i;
      end
   end

   // read side
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         rd_q <= '0;
      end else if (pop) begin
         rd_q <= rd_q + 1'b1;
      end
   end

endmodule : liuc_fifo

// >>> tb/liuc_framer_model.sv
`timescale 1ns/10ps

// framer stand-in: takes receive data on the edge that does not update it
module liuc_framer_model (
   input wire logic rclk_i,
   input wire logic inv_i,
   input wire logic pos_i,
   input wire logic neg_i,
   output logic [1:0] word_o,
   output logic samp_o
);
   initial begin
      word_o = 2'h0;
      samp_o = 1'b0;
   end

   always @(posedge rclk_i) begin
      if (inv_i) begin
         word_o = {pos_i, neg_i};
         samp_o = ~samp_o;
      end
   end

   always @(negedge rclk_i) begin
      if (!inv_i) begin
         word_o = {pos_i, neg_i};
         samp_o = ~samp_o;
      end
   end
endmodule : liuc_framer_model

// >>> tb/liuc_rx_strap_test.sv
`timescale 1ns/10ps
`include "liuc_consts.svh"

`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin mismatches++; \
   $display("[ERR] %s expected %0h seen %0h", nm, e, g); end end

module liuc_rx_strap_test;
   logic core_clk, link_clk, reset, pos_m, neg_m, valid, exp_inv, fs, acc;
   logic line_ready, bypass, rx_en, eq_en, host_serial_data_in, cs, rclk, receive_positive_data, receive_negative_data;
   liuc_pkg::liuc_pins_t pins;
   logic [3:0] hb; // host bits: power, equalizer, invert, single rail
   logic [1:0] fw;
   logic [1:0] lastw; // last accepted mark, tracked across runs like the design
   logic [2:0] e;
   logic [2:0] expq[$]; // {neg is dont care, pos, neg}
   int mismatches, tests_run, cnt;

   // free clocks, link rising edges land on core falling edges
   always #20 core_clk = ~core_clk;
   always #80 link_clk = ~link_clk;

   liuc_rx_strap liuc_rx_strap_inst (
      .core_clk_i(core_clk),
      .reset_i(reset),
      .link_clk_i(link_clk),
      .line_buildout_bypass_select_i(pins.buildout_bypass),
      .receiver_power_on_i(pins.rx_power_on),
      .receive_equalizer_enable_i(pins.eq_enable),
      .recovered_clock_invert_i(pins.clk_invert),
      .host_mode_i(pins.host_mode),
      .single_rail_i(pins.single_rail),
      .rate_sel_i(pins.rate),
      .host_rx_power_on_i(hb[3]),
      .host_equalizer_enable_i(hb[2]),
      .host_rx_clk_invert_i(hb[1]),
      .host_single_rail_i(hb[0]),
      .line_pos_mark_i(pos_m),
      .line_neg_mark_i(neg_m),
      .line_valid_i(valid),
      .line_ready_o(line_ready),
      .buildout_bypass_o(bypass),
      .receiver_enable_o(rx_en),
      .equalizer_enable_o(eq_en),
      .host_serial_data_in_o(host_serial_data_in),
      .host_chip_select_o(cs),
      .recovered_clock_out_o(rclk),
      .receive_positive_data_o(receive_positive_data),
      .receive_negative_data_o(receive_negative_data)
   );

   liuc_framer_model liuc_framer_model_inst (
      .rclk_i(rclk),
      .inv_i(exp_inv),
      .pos_i(receive_positive_data),
      .neg_i(receive_negative_data),
      .word_o(fw),
      .samp_o(fs)
   );

   // each marked sample takes the oldest note off the queue
   always @(fs) begin
      if (fw != 2'h0) begin
         e = (expq.size() == 0) ? 3'h0 : expq.pop_front();
         `CHK("rx pos", e[1], fw[1])
         if (!e[2]) `CHK("rx neg", e[0], fw[0])
      end
   end

   task automatic settle();
      repeat (12) @(posedge link_clk);
      #1;
   endtask : settle

   // select level stands for the cable length
   task automatic set_cfg(input liuc_pkg::liuc_pins_t p, input logic [3:0] h);
      @(posedge core_clk);
      #1;
      pins = p;
      hb = h;
      exp_inv = p.host_mode ? h[1] : p.clk_invert;
      settle();
   endtask : set_cfg

   task automatic check_straps();
      logic hm;
      hm = pins.host_mode;
      // ds3 and sts-1 codes are the two with exactly one bit set
      `CHK("bypass", !hm & pins.buildout_bypass & (^pins.rate), bypass)
      `CHK("rx enable", hm ? hb[3] : pins.rx_power_on, rx_en)
      `CHK("equalizer", hm ? hb[2] : pins.eq_enable, eq_en)
      `CHK("host data", hm & pins.rx_power_on, host_serial_data_in)
      `CHK("host select", hm & pins.clk_invert, cs)
      @(negedge link_clk);
      #20;
      `CHK("rclk", exp_inv, rclk)
      @(posedge link_clk);
      #1;
   endtask : check_straps

   task automatic push(input logic [1:0] w, output logic ok);
      pos_m = w[1];
      neg_m = w[0];
      valid = 1'b1;
      ok = line_ready;
      @(posedge link_clk);
      #1;
   endtask : push

   // random marks back to back; single rail ends with both marks at once
   task automatic run(input logic sr);
      logic [1:0] w, x;
      logic vio;
      for (int i = 0; i < 40; i++) begin
         w = sr ? 2'($urandom % 3) : 2'($urandom);
         push(w, acc);
         // violation: both marks, or same polarity as the last accepted mark
         vio = (w == 2'h3) || (w != 2'h0 && lastw != 2'h0 && w[1] == lastw[1]);
         x = {w[1], sr ? vio : w[0]};
         // only words that show on the outputs are noted
         if (acc && x != 2'h0) expq.push_back({1'b0, x});
         if (acc && w != 2'h0) lastw = w;
      end
      if (sr) begin
         push(2'h3, acc);
         expq.push_back(3'h3);
         lastw = 2'h3;
      end
      valid = 1'b0;
      settle();
   endtask : run

   task automatic done(input string nm);
      `CHK("notes left", 0, expq.size())
      $display("test %s finished", nm);
   endtask : done

   task automatic results();
      $display("comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : results

   // cut a hang short
   initial begin
      #500000;
      mismatches++;
      results();
   end

   // main sequence
   initial begin
      {core_clk, link_clk, pos_m, neg_m, valid, exp_inv, hb} = '0;
      pins = '0;
      lastw = 2'h0;
      reset = 1'b1;
      void'($urandom(32'hB6CDD497));
      repeat (3) @(posedge core_clk);
      #1;
      reset = 1'b0;
      settle();
      check_straps();
      done("reset");
      for (int i = 0; i < 12; i++) begin
         set_cfg(8'($urandom), 4'($urandom));
         check_straps();
      end
      done("straps");
      // hardware mode, receiver on, dual then single rail
      set_cfg(8'h04, 4'h0);
      run(1'b0);
      done("dual rail");
      set_cfg(8'h44, 4'h0);
      run(1'b1);
      done("single rail");
      // invert pin, then host mode with invert bit and single rail
      set_cfg(8'h05, 4'h0);
      check_straps();
      run(1'b0);
      done("inverted");
      set_cfg(8'h80, 4'hB);
      check_straps();
      run(1'b1);
      done("host");
      // receiver off stalls the buffer until it refuses
      set_cfg(8'h00, 4'h0);
      cnt = 0;
      for (int i = 0; i < 6; i++) begin
         push(2'h2, acc);
         if (acc) cnt++;
      end
      valid = 1'b0;
      `CHK("fill count", `LIUC_FIFO_DEPTH, cnt)
      `CHK("ready full", 1'b0, line_ready)
      repeat (cnt) expq.push_back(3'h2);
      settle();
      `CHK("held words", `LIUC_FIFO_DEPTH, expq.size())
      set_cfg(8'h04, 4'h0);
      done("buffer");
      results();
   end
endmodule : liuc_rx_strap_test
